// ==== design/wwdc_pkg.sv ====
package wwdc_pkg;
    localparam logic [7:0]  WWDC_SERVICE_CODE = 8'hac;
    localparam logic [7:0]  WWDC_READ_OPEN    = 8'h9a;
    localparam logic [7:0]  WWDC_READ_CLOSED  = 8'h1a;
    localparam int          WWDC_CNT_W        = 17;
    localparam logic [16:0] WWDC_CNT_RESET    = 17'h00000;
    // low-speed oscillator nominal 240 kHz against a 50 MHz system clock
    localparam int          WWDC_CLK_HZ       = 50000000;
    localparam int          WWDC_LS_HZ        = 240000;
    localparam int          WWDC_LS_DIV       = WWDC_CLK_HZ / WWDC_LS_HZ;
    localparam logic [7:0]  WWDC_LS_DIV_LAST  = 8'(WWDC_LS_DIV - 1);
    localparam logic [1:0]  WWDC_SEL2_RESET   = 2'h0;

    typedef enum logic [1:0] {
        WWDC_ST_FRESH = 2'b00,
        WWDC_ST_RUN   = 2'b01,
        WWDC_ST_RESET = 2'b10
    } wwdc_state_t;
endpackage : wwdc_pkg

// ==== design/wwdc_tick_div.sv ====
// one-cycle enable per low-speed oscillator period; freezes while the oscillator is halted
module wwdc_tick_div
    import wwdc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    logic [7:0] div_reg;
    logic [7:0] div_next;
    wire        at_last = (div_reg == WWDC_LS_DIV_LAST);

    assign div_next = at_last ? 8'h00 : div_reg + 8'h01;
    assign tick     = run && at_last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else if (run) begin
            div_reg <= div_next;
        end
    end
endmodule : wwdc_tick_div

// ==== design/wwdc_ctrl.sv ====
module wwdc_ctrl
    import wwdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       osc_run_option,
    input  wire logic       low_speed_osc_stop,
    input  wire logic       halt_or_stop,
    input  wire logic       flash_self_prog,
    input  wire logic [2:0] overflow_time_sel,
    input  wire logic [1:0] open_period_sel,
    input  wire logic       svc_wr,
    input  wire logic [7:0] svc_wdata,
    output logic [7:0]      svc_rdata,
    output logic            config_illegal,
    output logic            wdt_reset
);
    wwdc_state_t       state_reg, state_next;
    logic [16:0]       cnt_reg, cnt_next;
    logic              pend_reg, pend_next;
    logic              tick;

    // option bit 1 keeps the oscillator alive in sleep modes; flash work never stops it
    wire osc_run = osc_run_option || (!halt_or_stop && !low_speed_osc_stop);
    wire [16:0] limit = (17'h00400 << overflow_time_sel) - 17'h00001;
    // window opens after this fraction of the period: 100/25/50/0 percent -> closed share
    wire [16:0] open_at = (open_period_sel == 2'h3) ? 17'h00000 :
                          (open_period_sel == 2'h2) ? {1'b0, limit[16:1]} :
                          (open_period_sel == 2'h1) ? {2'b00, limit[16:2]} : limit;
    wire        win_open = (cnt_reg >= open_at);
    wire        good_code = (svc_wdata == WWDC_SERVICE_CODE);
    wire        fresh    = (state_reg == WWDC_ST_FRESH);
    wire        svc_ok   = svc_wr && good_code && (fresh || win_open);
    wire        svc_bad  = svc_wr && !svc_ok;
    // cnt_reg == limit is the last count; an accepted service write there still wins over overflow
    wire        overflow = tick && (cnt_reg == limit) && !svc_ok;

    wwdc_tick_div u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (osc_run),
        .tick  (tick)
    );

    assign config_illegal = (overflow_time_sel == 3'h0) && (open_period_sel == 2'h0);
    assign svc_rdata      = win_open ? WWDC_READ_OPEN : WWDC_READ_CLOSED;
    assign pend_next      = (pend_reg || svc_bad) && !tick;
    assign cnt_next = svc_ok ? WWDC_CNT_RESET :
                      tick   ? cnt_reg + 17'h00001 : cnt_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            WWDC_ST_FRESH,
            WWDC_ST_RUN: begin
                if (overflow || (tick && (pend_reg || svc_bad))) begin
                    state_next = WWDC_ST_RESET;
                end else if (svc_ok) begin
                    state_next = WWDC_ST_RUN;
                end
            end
            WWDC_ST_RESET: state_next = WWDC_ST_RESET;
            default:       state_next = WWDC_ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= WWDC_ST_FRESH;
            cnt_reg   <= WWDC_CNT_RESET;
            pend_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pend_reg  <= pend_next;
        end
    end

    // held until system reset clears the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_reset <= 1'b0;
        end else begin
            wdt_reset <= (state_next == WWDC_ST_RESET);
        end
    end

    hold_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!osc_run_option && halt_or_stop && !svc_wr) |=> $stable(cnt_reg))
        else $error("count moved while stopped");
    osc_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!osc_run_option && low_speed_osc_stop && !svc_wr && cnt_reg != 17'h0) |=> cnt_reg != 17'h0)
        else $error("count cleared while oscillator stopped");
    flash_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flash_self_prog && !halt_or_stop && !low_speed_osc_stop) |-> osc_run)
        else $error("count clock stopped during flash work");
    first_svc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (fresh && svc_wr && good_code && !overflow && !wdt_reset && !pend_reg) |=> (cnt_reg == 17'h0 && !wdt_reset))
        else $error("first service write did not clear");
    bad_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (svc_wr && !good_code && tick) |=> wdt_reset)
        else $error("bad code did not reset");
    read_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        svc_rdata != WWDC_SERVICE_CODE && svc_rdata[6:0] == 7'h1a)
        else $error("bad read value");
    last_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt_reg == limit && svc_ok && !wdt_reset && !pend_reg) |=> !wdt_reset && cnt_reg == 17'h0)
        else $error("last-count service failed");
    closed_svc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!fresh && svc_wr && !win_open && osc_run) |=> ##[0:300] wdt_reset)
        else $error("closed window service not punished");

    // helper logic for assertions only; it adds no behaviour
    logic [7:0]  gap_reg;
    logic [7:0]  gap_next;
    logic [15:0] hold_reg;
    logic [15:0] hold_next;
    wire         stalled = !osc_run_option && (halt_or_stop || low_speed_osc_stop);

    assign gap_next  = tick ? 8'h00 : (osc_run ? gap_reg + 8'h01 : gap_reg);
    // saturates so a very long sleep cannot wrap back to zero
    assign hold_next = (stalled && hold_reg != 16'hffff) ? hold_reg + 16'h0001 :
                       (stalled ? hold_reg : 16'h0000);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg  <= 8'h00;
            hold_reg <= 16'h0000;
        end else begin
            gap_reg  <= gap_next;
            hold_reg <= hold_next;
        end
    end

    sticky_rst_a: assert property (@(posedge clk) disable iff (!rst_n)
        wdt_reset
        |=> wdt_reset)
        else $error("internal reset request dropped");

    pend_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pend_reg && !tick)
        |=> pend_reg)
        else $error("deferred reset lost while clock stopped");

    pend_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick
        |=> !pend_reg)
        else $error("deferred reset kept after tick");

    cnt_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !svc_ok)
        |=> cnt_reg == $past(cnt_reg) + 17'h00001)
        else $error("count did not advance on tick");

    svc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        svc_ok
        |=> cnt_reg == WWDC_CNT_RESET)
        else $error("accepted service did not clear");

    overflow_rst_a: assert property (@(posedge clk) disable iff (!rst_n)
        overflow
        |=> wdt_reset)
        else $error("overflow did not reset");

    no_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        !osc_run
        |-> !tick)
        else $error("tick while oscillator stopped");

    stall_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        stalled
        |-> !tick)
        else $error("tick while asleep");

    read_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        win_open
        |-> svc_rdata == WWDC_READ_OPEN)
        else $error("wrong read code in open window");

    read_closed_a: assert property (@(posedge clk) disable iff (!rst_n)
        !win_open
        |-> svc_rdata == WWDC_READ_CLOSED)
        else $error("wrong read code in closed window");

    idle_rst_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!wdt_reset && !svc_wr && !pend_reg && !overflow)
        |=> !wdt_reset)
        else $error("reset without cause");

    tick_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick
        |-> gap_reg == WWDC_LS_DIV_LAST)
        else $error("tick spacing wrong");

    state_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |-> state_reg inside {WWDC_ST_FRESH, WWDC_ST_RUN, WWDC_ST_RESET})
        else $error("illegal state code");


    cov_service_c:  cover property (@(posedge clk) disable iff (!rst_n) svc_ok);
    cov_overflow_c: cover property (@(posedge clk) disable iff (!rst_n) overflow);
    cov_deferred_c: cover property (@(posedge clk) disable iff (!rst_n) pend_reg && !osc_run);
    cov_sleep_c:    cover property (@(posedge clk) disable iff (!rst_n) hold_reg == 16'h00ff);
    cov_last_c:     cover property (@(posedge clk) disable iff (!rst_n) svc_ok && cnt_reg == limit);
endmodule : wwdc_ctrl

// ==== tb/testbench.sv ====
module testbench
    import wwdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, rst_n = 0, osc_run_option = 0, low_speed_osc_stop = 0;
    logic       halt_or_stop = 0, flash_self_prog = 0, svc_wr = 0;
    logic [2:0] overflow_time_sel = 3'h7;
    logic [1:0] open_period_sel = 2'h3;
    logic [7:0] svc_wdata = 8'h00, svc_rdata, d;
    logic       config_illegal, wdt_reset;
    logic [31:0] seed = 32'h18a9b491, v;
    int         n_mismatch = 0, n_checks = 0, k;
    // reference model in integers, advanced on the same edges that the design samples
    int         m_div = 0, m_cnt = 0;
    bit         m_fresh = 1, m_pend = 0, m_rst = 0, m_run, m_tick, m_ok, m_bad;
    int         bad_q[$];
    function automatic int lim_of(input logic [2:0] s);
        return (1024 << s) - 1;
    endfunction : lim_of
    function automatic int open_of(input logic [2:0] s, input logic [1:0] w);
        case (w)
            2'h3: return 0;
            2'h2: return lim_of(s) / 2;
            2'h1: return lim_of(s) / 4;
            default: return lim_of(s);
        endcase
    endfunction : open_of
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_div = 0;
            m_cnt = 0;
            m_fresh = 1;
            m_pend = 0;
            m_rst = 0;
        end else begin
            m_run = osc_run_option || (!halt_or_stop && !low_speed_osc_stop);
            m_tick = m_run && (m_div == WWDC_LS_DIV - 1);
            m_ok = svc_wr && (svc_wdata == WWDC_SERVICE_CODE)
                && (m_fresh || m_cnt >= open_of(overflow_time_sel, open_period_sel));
            m_bad = svc_wr && !m_ok;
            if (m_bad) bad_q.push_back(m_cnt);
            if (m_tick && ((m_cnt == lim_of(overflow_time_sel) && !m_ok) || m_pend || m_bad)) m_rst = 1;
            if (m_tick) bad_q.delete();
            m_pend = (m_pend || m_bad) && !m_tick;
            if (m_ok) m_fresh = 0;
            m_cnt = m_ok ? 0 : (m_tick ? ((m_cnt + 1) & 32'h1ffff) : m_cnt);
            if (m_run) m_div = m_tick ? 0 : m_div + 1;
        end
    end
    always #10 clk = ~clk;
    wwdc_ctrl dut (.clk, .rst_n, .osc_run_option, .low_speed_osc_stop, .halt_or_stop, .flash_self_prog,
        .overflow_time_sel, .open_period_sel, .svc_wr, .svc_wdata, .svc_rdata, .config_illegal, .wdt_reset);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] x);
        @(posedge clk) begin svc_wr <= 1'b1; svc_wdata <= x; end
        @(posedge clk) svc_wr <= 1'b0;
    endtask : wr
    task automatic reboot();
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : reboot
    // a reset request is only expected after the next oscillator tick, so waits span two tick periods
    task automatic watch(input int n, input logic e);
        int i;
        if (e) for (i = 0; i < n && wdt_reset !== 1'b1; i++) @(posedge clk) #1;
        else repeat (n) @(posedge clk);
        #1;
        chk(8'(wdt_reset), 8'(m_rst));
        chk(8'(wdt_reset), 8'(e));
        if (wdt_reset !== e) close_out();
    endtask : watch
    function automatic logic [7:0] bad();
        logic [7:0] b;
        b = 8'(xs());
        return (b == 8'hac) ? 8'h53 : b;
    endfunction : bad
    initial begin
        reboot();
        repeat (8) begin
            v = xs();
            if (v[4:0] == 5'h00) v[3] = 1'b1;
            @(posedge clk) begin overflow_time_sel <= v[2:0]; open_period_sel <= v[4:3]; end
            #1;
            chk(8'(config_illegal), 8'(v[2:0] == 3'h0 && v[4:3] == 2'h0));
            chk(8'(svc_rdata == 8'h9a || svc_rdata == 8'h1a), 8'h01);
            if (v[4:3] == 2'h3) chk(svc_rdata, 8'h9a);
            chk(svc_rdata, (m_cnt >= open_of(v[2:0], v[4:3])) ? WWDC_READ_OPEN : WWDC_READ_CLOSED);
        end
        reboot();
        @(posedge clk) begin overflow_time_sel <= 3'h7; open_period_sel <= 2'h3; end
        wr(8'hac);
        wr(8'hac);
        watch(450, 1'b0);
        @(posedge clk) open_period_sel <= 2'h0;
        wr(8'hac);
        watch(450, 1'b1);
        reboot();
        wr(8'hac);
        watch(450, 1'b0);
        @(posedge clk) flash_self_prog <= 1'b1;
        wr(bad());
        watch(450, 1'b1);
        for (k = 0; k < 2; k++) begin
            reboot();
            @(posedge clk) begin halt_or_stop <= (k == 0); low_speed_osc_stop <= (k == 1); end
            wr(bad());
            watch(700, 1'b0);
            @(posedge clk) begin halt_or_stop <= 1'b0; osc_run_option <= (k == 1); end
            watch(450, 1'b1);
        end
        close_out();
    end
endmodule : testbench
